// ==== shared/pll_pkg.sv ====
`default_nettype none
package pll_pkg;

  // Register map, byte addresses on the Wishbone slave
  localparam logic [7:0] DIV_OFF = 8'h00;
  localparam logic [7:0] REF_OFF = 8'h04;
  localparam logic [7:0] CTRL_OFF = 8'h08;
  localparam logic [7:0] STAT_OFF = 8'h0C;
  localparam logic [7:0] CMD_OFF = 8'h10;

  // Programmable divider shape
  localparam int DIV_W = 15;
  localparam int SWALLOW_W = 4;
  localparam int MAIN_W = 11;
  localparam int PSC_W = 5;
  localparam logic [PSC_W-1:0] PSC_LOW_LAST = 5'h0F;
  localparam logic [PSC_W-1:0] PSC_HIGH_LAST = 5'h10;
  localparam logic [DIV_W-1:0] DIV_RST = 15'h0000;

  // Reference divider
  localparam int REF_CODE_W = 5;
  localparam int REF_CNT_W = 9;
  localparam logic [REF_CODE_W-1:0] REF_CODE_RST = 5'h00;
  localparam int REF_SRC_BIT = 8;

  // Control register fields
  localparam int CTRL_W = 7;
  localparam int CTRL_PORT_LSB = 0;
  localparam int CTRL_TEST_LSB = 1;
  localparam int CTRL_TEST_EN_BIT = 4;
  localparam int CTRL_BAND_LSB = 5;
  localparam logic [CTRL_W-1:0] CTRL_RST = 7'h00;

  // Status and command fields
  localparam int STAT_LOCK_BIT = 0;
  localparam int STAT_PEND_BIT = 1;
  localparam int CMD_STOP_BIT = 0;

  // Test selector codes that put an internal clock on the first port
  localparam logic [2:0] TEST_FPD_HALF = 3'h2;
  localparam logic [2:0] TEST_FCOMP = 3'h3;

  // Lock detector: error width per period and good periods to declare lock
  localparam logic [7:0] LOCK_ERR_MAX = 8'h02;
  localparam logic [3:0] LOCK_GOOD_LAST = 4'h7;

  typedef enum logic [1:0] {
    BAND_LOW = 2'b00,
    BAND_MID = 2'b01,
    BAND_HIGH = 2'b10
  } band_t;

  typedef enum logic [1:0] {
    LK_SEARCH = 2'b01,
    LK_LOCKED = 2'b10
  } lock_state_t;

  // Codes with a zero exponent in the x5/x6/x7 groups have no ratio
  function automatic logic ref_code_ok(input logic [REF_CODE_W-1:0] code);
    ref_code_ok = (code[4:3] == 2'b00) || (code[2:0] != 3'h0);
  endfunction

  function automatic logic [REF_CNT_W-1:0] ref_ratio(input logic [REF_CODE_W-1:0] code);
    logic [REF_CNT_W-1:0] mult;
    mult = {7'h00, code[4:3]} + 9'h004;
    if (code[4:3] == 2'b00) begin
      ref_ratio = 9'h002 << code[2:0];
    end else begin
      ref_ratio = mult << (code[2:0] - 3'h1);
    end
  endfunction

endpackage
`default_nettype wire

// ==== hw/pll_pfd.sv ====
`timescale 1ns/100ps
`default_nettype none
module pll_pfd
  import pll_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ref_pulse_i,
  input wire logic div_pulse_i,
  output logic pump_up_o,
  output logic pump_dn_o
);

  logic up_q;
  logic dn_q;
  logic up_d;
  logic dn_d;
  logic both;

  // Both flags high means the later edge has arrived; clear both at once
  assign both = (up_q | ref_pulse_i) & (dn_q | div_pulse_i);
  assign up_d = both ? 1'b0 : (up_q | ref_pulse_i);
  assign dn_d = both ? 1'b0 : (dn_q | div_pulse_i);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      up_q <= 1'b0;
      dn_q <= 1'b0;
    end else begin
      up_q <= up_d;
      dn_q <= dn_d;
    end
  end

  assign pump_up_o = up_q;
  assign pump_dn_o = dn_q;

endmodule
`default_nettype wire

// ==== hw/pll_synth.sv ====
// Chosen here: the Wishbone slave port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module pll_synth
  import pll_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] adr_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  input wire logic [3:0] sel_i,
  input wire logic we_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  output logic ack_o,
  input wire logic [2:0] lo_band_i,
  input wire logic ref_xtal_i,
  input wire logic ref_ext_i,
  output logic pump_up_o,
  output logic pump_dn_o,
  output logic [3:0] switch_port_o,
  output logic [3:0] switch_port_oe_o,
  output logic lock_flag_o
);

  // Bus slave
  logic ack_q;
  logic [31:0] rdata_q;
  logic req;
  logic wr;
  logic hit_div;
  logic hit_ref;
  logic hit_ctrl;
  logic hit_stat;
  logic hit_cmd;
  logic [31:0] rdata_d;

  // Software state
  logic [DIV_W-1:0] div_q;
  logic [DIV_W-1:0] div_d;
  logic [6:0] stage_hi_q;
  logic [6:0] stage_hi_d;
  logic pend_q;
  logic pend_d;
  logic div_load;
  logic [REF_CODE_W-1:0] ref_code_q;
  logic [REF_CODE_W-1:0] ref_code_d;
  logic ref_src_q;
  logic ref_src_d;
  logic [CTRL_W-1:0] ctrl_q;
  logic [CTRL_W-1:0] ctrl_d;
  logic stop_wr;

  // Input synchronisers and edge detect
  logic [2:0] lo_s1_q;
  logic [2:0] lo_s2_q;
  logic [1:0] ref_s1_q;
  logic [1:0] ref_s2_q;
  logic lo_prev_q;
  logic ref_prev_q;
  logic lo_sel;
  logic ref_sel;
  logic lo_edge;
  logic ref_edge;
  logic [1:0] band_select_field;

  // Programmable divider
  logic [PSC_W-1:0] psc_q;
  logic [PSC_W-1:0] psc_d;
  logic [MAIN_W-1:0] main_q;
  logic [MAIN_W-1:0] main_d;
  logic [SWALLOW_W-1:0] swal_q;
  logic [SWALLOW_W-1:0] swal_d;
  logic [MAIN_W-1:0] div_main;
  logic [SWALLOW_W-1:0] div_swal;
  logic psc_end;
  logic main_end;
  logic fpd_q;
  logic fpd_half_q;

  // Reference divider
  logic [REF_CNT_W-1:0] ref_cnt_q;
  logic [REF_CNT_W-1:0] ref_cnt_d;
  logic [REF_CNT_W-1:0] ratio_last;
  logic ref_end;
  logic fcomp_q;

  // Lock detector
  lock_state_t lock_state_q;
  lock_state_t lock_state_d;
  logic [7:0] err_cnt_q;
  logic [7:0] err_cnt_d;
  logic [3:0] good_cnt_q;
  logic [3:0] good_cnt_d;
  logic period_good;

  // Ports
  logic test_enable_bit;
  logic [2:0] test_selector_field;
  logic first_switch_output;
  logic [3:0] port_on_q;
  logic [3:0] port_on_d;

  // ---------------------------------------------------------------- bus
  // One wait state: ack the cycle after the request, then drop it
  assign req = cyc_i & stb_i & ~ack_q;
  assign wr = req & we_i;
  assign hit_div = (adr_i == DIV_OFF);
  assign hit_ref = (adr_i == REF_OFF);
  assign hit_ctrl = (adr_i == CTRL_OFF);
  assign hit_stat = (adr_i == STAT_OFF);
  assign hit_cmd = (adr_i == CMD_OFF);
  assign stop_wr = wr & hit_cmd & sel_i[0] & dat_i[CMD_STOP_BIT];

  // Unmapped addresses read zero and swallow writes
  assign rdata_d = hit_div ? {17'h00000, div_q} :
                   hit_ref ? {23'h000000, ref_src_q, 3'h0, ref_code_q} :
                   hit_ctrl ? {25'h0000000, ctrl_q} :
                   hit_stat ? {30'h00000000, pend_q,
                               (lock_state_q == LK_LOCKED)} :
                   32'h00000000;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      rdata_q <= 32'h00000000;
    end else begin
      ack_q <= req;
      rdata_q <= (req & ~we_i) ? rdata_d : rdata_q;
    end
  end

  assign ack_o = ack_q;
  assign dat_o = rdata_q;

  // ---------------------------------------------------------------- division value
  // The upper byte alone is only staged, so a half-written ratio never
  // reaches the counters and the loop does not jump during fine tuning.
  always_comb begin
    div_d = div_q;
    stage_hi_d = stage_hi_q;
    pend_d = pend_q;
    div_load = 1'b0;
    if (wr & hit_div & sel_i[1] & sel_i[0]) begin
      div_d = dat_i[DIV_W-1:0];
      pend_d = 1'b0;
      div_load = 1'b1;
    end else if (wr & hit_div & sel_i[1]) begin
      stage_hi_d = dat_i[14:8];
      pend_d = 1'b1;
    end else if (wr & hit_div & sel_i[0]) begin
      div_d = {pend_q ? stage_hi_q : div_q[14:8], dat_i[7:0]};
      pend_d = 1'b0;
      div_load = 1'b1;
    end else if (stop_wr & pend_q) begin
      div_d = {stage_hi_q, div_q[7:0]};
      pend_d = 1'b0;
      div_load = 1'b1;
    end
  end

  // Refused reference codes leave the old ratio in place
  assign ref_code_d = (wr & hit_ref & sel_i[0] & ref_code_ok(dat_i[REF_CODE_W-1:0])) ?
                      dat_i[REF_CODE_W-1:0] : ref_code_q;
  assign ref_src_d = (wr & hit_ref & sel_i[1]) ? dat_i[REF_SRC_BIT] : ref_src_q;
  assign ctrl_d = (wr & hit_ctrl & sel_i[0]) ? dat_i[CTRL_W-1:0] : ctrl_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_q <= DIV_RST;
      stage_hi_q <= 7'h00;
      pend_q <= 1'b0;
      ref_code_q <= REF_CODE_RST;
      ref_src_q <= 1'b0;
      ctrl_q <= CTRL_RST;
    end else begin
      div_q <= div_d;
      stage_hi_q <= stage_hi_d;
      pend_q <= pend_d;
      ref_code_q <= ref_code_d;
      ref_src_q <= ref_src_d;
      ctrl_q <= ctrl_d;
    end
  end

  // ---------------------------------------------------------------- inputs
  // Oscillator and reference pins are asynchronous; each must stay below
  // half of clk_i or edges are lost.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lo_s1_q <= 3'h0;
      lo_s2_q <= 3'h0;
      ref_s1_q <= 2'h0;
      ref_s2_q <= 2'h0;
      lo_prev_q <= 1'b0;
      ref_prev_q <= 1'b0;
    end else begin
      lo_s1_q <= lo_band_i;
      lo_s2_q <= lo_s1_q;
      ref_s1_q <= {ref_ext_i, ref_xtal_i};
      ref_s2_q <= ref_s1_q;
      lo_prev_q <= lo_sel;
      ref_prev_q <= ref_sel;
    end
  end

  assign band_select_field = ctrl_q[CTRL_BAND_LSB +: 2];
  assign lo_sel = (band_select_field == BAND_LOW) ? lo_s2_q[0] :
                  (band_select_field == BAND_MID) ? lo_s2_q[1] :
                  (band_select_field == BAND_HIGH) ? lo_s2_q[2] : 1'b0;
  assign ref_sel = ref_src_q ? ref_s2_q[1] : ref_s2_q[0];
  assign lo_edge = lo_sel & ~lo_prev_q;
  assign ref_edge = ref_sel & ~ref_prev_q;

  // ---------------------------------------------------------------- divider
  assign div_main = div_q[DIV_W-1:SWALLOW_W];
  assign div_swal = div_q[SWALLOW_W-1:0];

  // 17 while the swallow count remains, 16 afterwards: A periods of 17
  // plus M-A of 16 give 16*M+A, valid only while A <= M.
  assign psc_end = lo_edge &
                   (psc_q == ((swal_q != 4'h0) ? PSC_HIGH_LAST : PSC_LOW_LAST));
  assign main_end = psc_end & (main_q <= 11'h001);

  always_comb begin
    psc_d = psc_q;
    main_d = main_q;
    swal_d = swal_q;
    if (div_load) begin
      psc_d = 5'h00;
      main_d = div_d[DIV_W-1:SWALLOW_W];
      swal_d = div_d[SWALLOW_W-1:0];
    end else if (lo_edge) begin
      psc_d = psc_end ? 5'h00 : psc_q + 5'h01;
      if (main_end) begin
        main_d = div_main;
        swal_d = div_swal;
      end else if (psc_end) begin
        main_d = main_q - 11'h001;
        swal_d = (swal_q != 4'h0) ? swal_q - 4'h1 : swal_q;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      psc_q <= 5'h00;
      main_q <= 11'h000;
      swal_q <= 4'h0;
      fpd_q <= 1'b0;
      fpd_half_q <= 1'b0;
    end else begin
      psc_q <= psc_d;
      main_q <= main_d;
      swal_q <= swal_d;
      // A zero main count stops the divider instead of dividing by one
      fpd_q <= main_end & (div_main != 11'h000);
      fpd_half_q <= fpd_half_q ^ fpd_q;
    end
  end

  // ---------------------------------------------------------------- reference
  assign ratio_last = ref_ratio(ref_code_q) - 9'h001;
  assign ref_end = ref_edge & (ref_cnt_q >= ratio_last);
  assign ref_cnt_d = ref_end ? 9'h000 : (ref_edge ? ref_cnt_q + 9'h001 : ref_cnt_q);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ref_cnt_q <= 9'h000;
      fcomp_q <= 1'b0;
    end else begin
      ref_cnt_q <= ref_cnt_d;
      fcomp_q <= ref_end;
    end
  end

  // ---------------------------------------------------------------- comparator
  pll_pfd u_pfd (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ref_pulse_i(fcomp_q),
    .div_pulse_i(fpd_q),
    .pump_up_o(pump_up_o),
    .pump_dn_o(pump_dn_o)
  );

  // ---------------------------------------------------------------- lock
  // Lock needs several consecutive periods with a short pump pulse, so one
  // lucky edge cannot raise the flag; one wide pulse drops it.
  assign err_cnt_d = fcomp_q ? 8'h00 :
                     ((pump_up_o | pump_dn_o) & (err_cnt_q != 8'hFF)) ?
                     err_cnt_q + 8'h01 : err_cnt_q;
  assign period_good = (err_cnt_q <= LOCK_ERR_MAX);

  always_comb begin
    lock_state_d = lock_state_q;
    good_cnt_d = good_cnt_q;
    if (fcomp_q) begin
      case (lock_state_q)
        LK_SEARCH: begin
          if (!period_good) begin
            good_cnt_d = 4'h0;
          end else if (good_cnt_q == LOCK_GOOD_LAST) begin
            lock_state_d = LK_LOCKED;
            good_cnt_d = 4'h0;
          end else begin
            good_cnt_d = good_cnt_q + 4'h1;
          end
        end
        LK_LOCKED: begin
          if (!period_good) begin
            lock_state_d = LK_SEARCH;
          end
        end
        default: begin
          lock_state_d = LK_SEARCH;
          good_cnt_d = 4'h0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lock_state_q <= LK_SEARCH;
      err_cnt_q <= 8'h00;
      good_cnt_q <= 4'h0;
    end else begin
      lock_state_q <= lock_state_d;
      err_cnt_q <= err_cnt_d;
      good_cnt_q <= good_cnt_d;
    end
  end

  assign lock_flag_o = (lock_state_q == LK_LOCKED);

  // ---------------------------------------------------------------- ports
  // Test mode reuses the port bits as selector, so normal port data is lost
  assign test_enable_bit = ctrl_q[CTRL_TEST_EN_BIT];
  assign test_selector_field = ctrl_q[CTRL_TEST_LSB +: 3];
  assign first_switch_output = (test_selector_field == TEST_FPD_HALF) ? fpd_half_q :
                               (test_selector_field == TEST_FCOMP) ? fcomp_q : 1'b0;
  assign port_on_d = test_enable_bit ? {3'h0, first_switch_output} :
                     ctrl_q[CTRL_PORT_LSB +: 4];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      port_on_q <= 4'h0;
    end else begin
      port_on_q <= port_on_d;
    end
  end

  // Open collector: an on port sinks to low, an off port floats
  assign switch_port_o = 4'h0;
  assign switch_port_oe_o = port_on_q;

endmodule
`default_nettype wire

// ==== verif/pll_synth_chk.sv ====
`timescale 1ns/100ps
`default_nettype none
module pll_synth_chk
  import pll_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] adr_i,
  input wire logic [31:0] dat_o,
  input wire logic we_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic ack_o,
  input wire logic pump_up_o,
  input wire logic pump_dn_o,
  input wire logic [3:0] switch_port_o,
  input wire logic [3:0] switch_port_oe_o,
  input wire logic lock_flag_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  wire logic req = cyc_i && stb_i;
  wire logic rd_req = req && !we_i;
  wire logic wr_ctrl = req && we_i && adr_i == CTRL_OFF;

  a_ack_single: assert property (ack_o |=> !ack_o)
    else $error("ack held two cycles");
  a_ack_answer: assert property (req && !ack_o |=> ack_o)
    else $error("request not answered next cycle");
  a_ack_cause: assert property (ack_o |-> $past(req))
    else $error("ack without request");
  a_port_open: assert property (switch_port_o == 4'h0)
    else $error("port level driven high");
  a_pump_apart: assert property (!(pump_up_o && pump_dn_o))
    else $error("both pump outputs active");
  a_reset_idle: assert property ($fell(rst_i) |-> !ack_o && switch_port_oe_o == 4'h0
    && !lock_flag_o && !pump_up_o && !pump_dn_o)
    else $error("outputs not idle after reset");
  a_port_cause: assert property ($changed(switch_port_oe_o[3:1]) && !$past(rst_i)
    |-> $past(wr_ctrl) || $past(wr_ctrl, 2))
    else $error("port changed without control write");
  a_cmd_zero: assert property (ack_o && $past(rd_req && adr_i == CMD_OFF) |-> dat_o == 32'h0)
    else $error("command register read nonzero");
  a_hole_zero: assert property (ack_o && $past(rd_req && adr_i > CMD_OFF) |-> dat_o == 32'h0)
    else $error("unmapped read nonzero");
  a_lock_read: assert property (ack_o && $past(rd_req && adr_i == STAT_OFF)
    |-> dat_o[0] == $past(lock_flag_o))
    else $error("status lock bit differs from flag");
endmodule

bind pll_synth pll_synth_chk i_chk (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_o(dat_o),
  .we_i(we_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o), .pump_up_o(pump_up_o),
  .pump_dn_o(pump_dn_o), .switch_port_o(switch_port_o), .switch_port_oe_o(switch_port_oe_o),
  .lock_flag_o(lock_flag_o));
`default_nettype wire

// ==== verif/pll_osc_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module pll_osc_model (
  input wire logic steer_i,
  input wire logic up_i,
  input wire logic dn_i,
  output logic [2:0] band_o,
  output logic xtal_o,
  output logic ext_o
);
  real d;
  initial begin
    band_o = 3'h0;
    xtal_o = 1'b0;
    ext_o = 1'b0;
  end
  // Pumps only nudge phase; no loop filter model, enough to pull the loop in
  always begin
    d = 12.5 - ((steer_i && up_i) ? 1.0 : 0.0) + ((steer_i && dn_i) ? 1.0 : 0.0);
    #d band_o[0] = ~band_o[0];
  end
  always #15.0 band_o[1] = ~band_o[1];
  always #10.0 band_o[2] = ~band_o[2];
  always #82.5 xtal_o = ~xtal_o;
  always #50.0 ext_o = ~ext_o;
endmodule
`default_nettype wire

// ==== verif/tb_pll_synth.sv ====
`timescale 1ns/100ps
`default_nettype none
module tb_pll_synth;
  import pll_pkg::*;
  logic clk_i, rst_i, we_i, cyc_i, stb_i, ack_o, pump_up_o, pump_dn_o, lock_flag_o;
  logic xtal, ext, steer;
  logic [2:0] band;
  logic [3:0] sel_i, switch_port_o, switch_port_oe_o;
  logic [7:0] adr_i;
  logic [31:0] dat_i, dat_o, rd;
  int num_errors, total_checks, n, up, dn;
  int bp[4] = '{330, 396, 264, 0};
  int dv[3] = '{'h21, 'h22, 'h30};
  int dp[3] = '{330, 340, 480};
  int rc[4] = '{0, 9, 19, 25};
  int rp[4] = '{66, 165, 792, 231};

  pll_synth i_dut (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i), .dat_o(dat_o),
    .sel_i(sel_i), .we_i(we_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o),
    .lo_band_i(band), .ref_xtal_i(xtal), .ref_ext_i(ext), .pump_up_o(pump_up_o),
    .pump_dn_o(pump_dn_o), .switch_port_o(switch_port_o),
    .switch_port_oe_o(switch_port_oe_o), .lock_flag_o(lock_flag_o));
  pll_osc_model i_osc (.steer_i(steer), .up_i(pump_up_o), .dn_i(pump_dn_o), .band_o(band),
    .xtal_o(xtal), .ext_o(ext));

  // Odd start offset keeps oscillator edges off the sampling edge
  initial begin
    clk_i = 1'b0;
    #1.1;
    forever #2.5 clk_i = ~clk_i;
  end

  task automatic wrap_up();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d,
                    input logic [3:0] s);
    int k;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    adr_i <= a;
    we_i <= w;
    dat_i <= d;
    sel_i <= s;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (ack_o !== 1'b1 && k < 20);
    if (ack_o !== 1'b1) begin
      num_errors++;
      $display("unexpected at %0t: no ack", $time);
      wrap_up();
    end
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    wb(a, 1'b1, d, s);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    wb(a, 1'b0, 32'h0, 4'hF);
    check(rd, exp);
  endtask

  // Cycles between two rising edges of port 0, zero if fewer than two seen
  task automatic period(input int exp);
    int k, e, t0;
    logic p;
    p = 1'b1;
    e = 0;
    t0 = 0;
    for (k = 0; k < 4000 && e < 2; k++) begin
      @(posedge clk_i);
      if (switch_port_oe_o[0] === 1'b1 && p !== 1'b1) begin
        e++;
        n = k - t0;
        t0 = k;
      end
      p = switch_port_oe_o[0];
    end
    check((e < 2) ? 0 : n, exp);
    // A lost divider or reference means later scenarios measure nothing
    if (e < 2 && exp != 0) begin
      wrap_up();
    end
  endtask

  initial begin
    rst_i = 1'b1;
    cyc_i = 1'b0;
    stb_i = 1'b0;
    we_i = 1'b0;
    adr_i = 8'h00;
    dat_i = 32'h0;
    sel_i = 4'h0;
    steer = 1'b0;
    num_errors = 0;
    total_checks = 0;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    check({lock_flag_o, switch_port_oe_o}, 32'h0);
    rdc(CTRL_OFF, 32'h0);
    for (int i = 0; i < 4; i++) begin
      wr(CTRL_OFF, 32'h1 << i, 4'hF);
      check(switch_port_oe_o, 4'h1 << i);
    end
    wr(DIV_OFF, 32'h21, 4'h3);
    rdc(DIV_OFF, 32'h21);
    wr(DIV_OFF, 32'h0500, 4'h2);
    rdc(DIV_OFF, 32'h21);
    rdc(STAT_OFF, 32'h2);
    wr(DIV_OFF, 32'h34, 4'h1);
    rdc(DIV_OFF, 32'h534);
    wr(DIV_OFF, 32'h0100, 4'h2);
    wr(CMD_OFF, 32'h1, 4'h1);
    rdc(DIV_OFF, 32'h134);
    rdc(CMD_OFF, 32'h0);
    wr(8'h40, 32'hFF, 4'hF);
    rdc(8'h40, 32'h0);
    wr(REF_OFF, 32'h3, 4'hF);
    for (int i = 1; i < 4; i++) begin
      wr(REF_OFF, i << 3, 4'hF);
      rdc(REF_OFF, 32'h3);
    end
    wr(DIV_OFF, 32'h21, 4'h3);
    for (int b = 0; b < 4; b++) begin
      wr(CTRL_OFF, (b << 5) | 32'h14, 4'hF);
      period(bp[b]);
    end
    wr(CTRL_OFF, 32'h14, 4'hF);
    check(switch_port_oe_o[3:1], 3'h0);
    for (int i = 0; i < 3; i++) begin
      wr(DIV_OFF, dv[i], 4'h3);
      period(dp[i]);
    end
    wr(CTRL_OFF, 32'h16, 4'hF);
    for (int i = 0; i < 4; i++) begin
      wr(REF_OFF, rc[i], 4'hF);
      period(rp[i]);
    end
    wr(REF_OFF, 32'h100, 4'hF);
    rdc(REF_OFF, 32'h100);
    period(40);
    wr(REF_OFF, 32'h9, 4'hF);
    wr(DIV_OFF, 32'h21, 4'h3);
    wr(CTRL_OFF, 32'h0, 4'hF);
    steer <= 1'b1;
    for (n = 0; n < 40000 && lock_flag_o !== 1'b1; n++) begin
      @(posedge clk_i);
    end
    check(lock_flag_o, 1'b1);
    if (lock_flag_o !== 1'b1) begin
      wrap_up();
    end
    rdc(STAT_OFF, 32'h1);
    steer <= 1'b0;
    wr(DIV_OFF, 32'h22, 4'h3);
    up = 0;
    dn = 0;
    for (n = 0; n < 2000; n++) begin
      @(posedge clk_i);
      up += pump_up_o;
      dn += pump_dn_o;
    end
    check(lock_flag_o, 1'b0);
    check(up > dn, 1'b1);
    wrap_up();
  end
endmodule
`default_nettype wire
